/* File: rtl/timer_trio.v */
`timescale 1ns/10ps
`include "timer_trio_defs.vh"
module timer_trio #(
  parameter BASE_CYCLES = `BASE_CYC
) (
  // clock and reset
  input  wire        clk,
  input  wire        rst_b,
  // axi4-lite write address
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [5:0]  s_axi_awaddr,
  // axi4-lite write data
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  output reg  [1:0]  s_axi_bresp,
  // axi4-lite read address
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  input  wire [5:0]  s_axi_araddr,
  // axi4-lite read data
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  // interrupts
  output reg         timer1Irq_q,
  output reg         timer2Irq_q,
  output reg         irq_q
);

  // ****************************************
  // address decode
  // ****************************************
  function mapped;
    input [5:0] a;
    begin
      mapped = (a[1:0] == 2'h0) && (a <= `OFS_IRQ_MASK);
    end
  endfunction

  // ****************************************
  // registers
  // ****************************************
  reg  [1:0]  t12En_q;
  reg  [1:0]  t12Mode_q;
  reg  [15:0] t1Init_q;
  reg  [15:0] t2Init_q;
  reg  [2:0]  t1Div_q;
  reg  [2:0]  t2Div_q;
  reg  [2:0]  t3Div_q;
  reg         t3En_q;
  reg  [1:0]  flags_q;
  reg  [1:0]  mask_q;
  reg  [15:0] t1Cnt_q;
  reg  [15:0] t2Cnt_q;
  reg  [15:0] t3Cnt_q;
  reg  [1:0]  t12EnPrev_q;
  reg         t3EnPrev_q;
  // declared early: the write block below clears a finished one-shot enable
  wire [1:0]  start;
  wire [1:0]  expire;
  wire [1:0]  oneShotDone;

  // ****************************************
  // shared counting clock: 125 Hz base, 7 binary stages above it
  // ****************************************
  reg  [31:0] baseCnt_q;
  reg  [6:0]  divChain_q;
  wire        baseTick = (baseCnt_q == BASE_CYCLES - 1);
  wire [7:0]  tickSel;
  always @(posedge clk) begin
    if (!rst_b) begin
      baseCnt_q  <= 32'h0;
      divChain_q <= 7'h00;
    end else begin
      baseCnt_q  <= baseTick ? 32'h0 : baseCnt_q + 32'h1;
      if (baseTick)
        divChain_q <= divChain_q + 7'h01;
    end
  end
  // code 111 ticks at the 125 Hz base; each lower code halves the rate
  // so one shared chain feeds all three timers
  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : gTick
      assign tickSel[g] = baseTick && (&divChain_q[6-g:0]);
    end
  endgenerate
  assign tickSel[7] = baseTick;

  wire t1Tick = tickSel[t1Div_q];
  wire t2Tick = tickSel[t2Div_q];
  wire t3Tick = tickSel[t3Div_q];

  // ****************************************
  // axi4-lite write path
  // ****************************************
  reg        awHeld_q;
  reg        wHeld_q;
  reg [5:0]  awAddr_q;
  reg [31:0] wData_q;
  reg [3:0]  wStrb_q;
  wire       doWrite = awHeld_q && wHeld_q && !s_axi_bvalid;
  wire       lo = wStrb_q[0];
  wire       hi = wStrb_q[1];
  always @(posedge clk) begin
    if (!rst_b) begin
      awHeld_q      <= 1'b0;
      wHeld_q       <= 1'b0;
      awAddr_q      <= 6'h00;
      wData_q       <= 32'h0;
      wStrb_q       <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
    end else begin
      s_axi_awready <= !awHeld_q && !s_axi_awready;
      s_axi_wready  <= !wHeld_q && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q      <= 1'b1;
        awAddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q      <= 1'b1;
        wData_q      <= s_axi_wdata;
        wStrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld_q     <= 1'b0;
        wHeld_q      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= mapped(awAddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // axi4-lite read path
  // ****************************************
  reg  [31:0] rdMux;
  wire        doRead = s_axi_arvalid && s_axi_arready;
  wire        flagsRead = doRead && (s_axi_araddr == `OFS_FLAGS);
  always @* begin
    rdMux = 32'h0;
    case (s_axi_araddr)
      `OFS_T1_CTRL:  rdMux[15:14] = {t12En_q[0], t12Mode_q[0]};
      `OFS_T1_INIT:  rdMux[15:0]  = t1Init_q;
      `OFS_T2_CTRL:  rdMux[15:14] = {t12En_q[1], t12Mode_q[1]};
      `OFS_T2_INIT:  rdMux[15:0]  = t2Init_q;
      `OFS_FLAGS:    rdMux[1:0]   = flags_q;
      `OFS_T1_DIV:   rdMux[2:0]   = t1Div_q;
      `OFS_T2_DIV:   rdMux[2:0]   = t2Div_q;
      `OFS_T3_CTRL:  rdMux[`BIT_T3_EN] = t3En_q;
      `OFS_T3_COUNT: rdMux[15:0]  = t3Cnt_q;
      `OFS_T3_DIV:   rdMux[2:0]   = t3Div_q;
      `OFS_IRQ_MASK: rdMux[1:0]   = mask_q;
      default:       rdMux = 32'h0;
    endcase
  end
  always @(posedge clk) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (doRead) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdMux;
        s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************
  // software-written registers
  // ****************************************
  wire wrHit = doWrite && mapped(awAddr_q);
  always @(posedge clk) begin
    if (!rst_b) begin
      t12En_q   <= 2'h0;
      t12Mode_q <= 2'h0;
      t1Init_q  <= `INIT_RESET;
      t2Init_q  <= `INIT_RESET;
      t1Div_q   <= `DIV_RESET;
      t2Div_q   <= `DIV_RESET;
      t3Div_q   <= `DIV_RESET;
      t3En_q    <= 1'b0;
      mask_q    <= 2'h0;
    end else begin
      // one-shot expiry drops the enable so a new write restarts it
      if (oneShotDone[0])
        t12En_q[0] <= 1'b0;
      if (oneShotDone[1])
        t12En_q[1] <= 1'b0;
      if (wrHit) begin
        case (awAddr_q)
          `OFS_T1_CTRL: if (hi) begin
            t12En_q[0]   <= wData_q[`BIT_EN];
            t12Mode_q[0] <= wData_q[`BIT_MODE];
          end
          `OFS_T2_CTRL: if (hi) begin
            t12En_q[1]   <= wData_q[`BIT_EN];
            t12Mode_q[1] <= wData_q[`BIT_MODE];
          end
          `OFS_T1_INIT: begin
            if (lo) t1Init_q[7:0]  <= wData_q[7:0];
            if (hi) t1Init_q[15:8] <= wData_q[15:8];
          end
          `OFS_T2_INIT: begin
            if (lo) t2Init_q[7:0]  <= wData_q[7:0];
            if (hi) t2Init_q[15:8] <= wData_q[15:8];
          end
          `OFS_T1_DIV:   if (lo) t1Div_q <= wData_q[2:0];
          `OFS_T2_DIV:   if (lo) t2Div_q <= wData_q[2:0];
          `OFS_T3_DIV:   if (lo) t3Div_q <= wData_q[2:0];
          `OFS_T3_CTRL:  if (lo) t3En_q <= wData_q[`BIT_T3_EN];
          `OFS_IRQ_MASK: if (lo) mask_q <= wData_q[1:0];
          default: ;
        endcase
      end
    end
  end

  // ****************************************
  // timers one and two
  // ****************************************
  // both timers share one body; slice k of each packed word is timer k+1
  wire [1:0]  tick12 = {t2Tick, t1Tick};
  wire [31:0] init12 = {t2Init_q, t1Init_q};
  wire [31:0] cnt12  = {t2Cnt_q, t1Cnt_q};
  wire [31:0] cnt12_d;
  genvar k;
  generate
    for (k = 0; k < 2; k = k + 1) begin : gTimer
      wire [15:0] cntNow  = cnt12[16*k+15:16*k];
      wire [15:0] initNow = init12[16*k+15:16*k];
      wire        atOne   = (cntNow == `CNT_ONE);
      wire        live    = (cntNow != `CNT_ZERO);
      reg  [15:0] cnt_d;
      assign start[k]       = t12En_q[k] && !t12EnPrev_q[k];
      // the load cycle never counts, so a tick there cannot expire
      assign expire[k]      = t12En_q[k] && !start[k] && tick12[k] && atOne;
      assign oneShotDone[k] = expire[k] && !t12Mode_q[k];
      // init is only sampled at start or reload, never mid-count
      always @* begin
        cnt_d = cntNow;
        if (start[k])
          cnt_d = initNow;
        else if (expire[k] && t12Mode_q[k])
          cnt_d = initNow;
        else if (t12En_q[k] && tick12[k] && live)
          cnt_d = cntNow - `CNT_ONE;
      end
      assign cnt12_d[16*k+15:16*k] = cnt_d;
    end
  endgenerate
  always @(posedge clk) begin
    if (!rst_b) begin
      t1Cnt_q     <= `CNT_ZERO;
      t2Cnt_q     <= `CNT_ZERO;
      t12EnPrev_q <= 2'h0;
    end else begin
      t12EnPrev_q <= t12En_q;
      t1Cnt_q     <= cnt12_d[15:0];
      t2Cnt_q     <= cnt12_d[31:16];
    end
  end

  // ****************************************
  // free-running timer three
  // ****************************************
  wire        t3Start = t3En_q && !t3EnPrev_q;
  reg  [15:0] t3Cnt_d;
  always @* begin
    t3Cnt_d = t3Cnt_q;
    // wraps through zero and only halts when t3En_q is cleared
    if (t3Start)
      t3Cnt_d = `CNT_ZERO;
    else if (t3En_q && t3Tick)
      t3Cnt_d = t3Cnt_q - `CNT_ONE;
  end
  always @(posedge clk) begin
    if (!rst_b) begin
      t3Cnt_q    <= `CNT_ZERO;
      t3EnPrev_q <= 1'b0;
    end else begin
      t3EnPrev_q <= t3En_q;
      t3Cnt_q    <= t3Cnt_d;
    end
  end

  // ****************************************
  // status flags and interrupts
  // ****************************************
  // a read clears, but an expiry in the same cycle still wins
  wire [1:0] flags_d = (flagsRead ? 2'h0 : flags_q) | expire;
  always @(posedge clk) begin
    if (!rst_b) begin
      flags_q     <= 2'h0;
      timer1Irq_q <= 1'b0;
      timer2Irq_q <= 1'b0;
      irq_q       <= 1'b0;
    end else begin
      flags_q     <= flags_d;
      timer1Irq_q <= expire[0];
      timer2Irq_q <= expire[1];
      // level follows the flags word that is being stored this cycle
      irq_q       <= |(flags_d & mask_q);
    end
  end

endmodule // timer_trio

/* File: rtl/timer_trio_defs.vh */
`ifndef TIMER_TRIO_DEFS_VH
`define TIMER_TRIO_DEFS_VH
// ****************************************
// register byte offsets
// ****************************************
`define OFS_T1_CTRL   6'h00
`define OFS_T1_INIT   6'h04
`define OFS_T2_CTRL   6'h08
`define OFS_T2_INIT   6'h0C
`define OFS_FLAGS     6'h10
`define OFS_T1_DIV    6'h14
`define OFS_T2_DIV    6'h18
`define OFS_T3_CTRL   6'h1C
`define OFS_T3_COUNT  6'h20
`define OFS_T3_DIV    6'h24
`define OFS_IRQ_MASK  6'h28
// ****************************************
// fields and reset values
// ****************************************
`define BIT_EN        15
`define BIT_MODE      14
`define BIT_T3_EN     0
`define DIV_RESET     3'h4
`define INIT_RESET    16'hFFFF
`define CNT_ZERO      16'h0000
`define CNT_ONE       16'h0001
// ****************************************
// shared tick: 125 Hz base at 200 MHz clock
// ****************************************
`define CLK_HZ        200000000
`define BASE_HZ       125
`define BASE_CYC      (`CLK_HZ / `BASE_HZ)
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

/* File: sim/timer_trio_monitor.sv */
`timescale 1ns/10ps
module timer_trio_monitor (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // bus
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  // interrupts
  input wire logic        timer1Irq_q,
  input wire logic        timer2Irq_q,
  input wire logic        irq_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ********
  // checks
  // ********
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("b dropped");
  bresp_code_a: assert property (s_axi_bvalid
    |-> s_axi_bresp == 2'h0 || s_axi_bresp == 2'h2) else $error("bresp");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("r dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid) else $error("read late");
  upper_zero_a: assert property (s_axi_rvalid
    |-> s_axi_rdata[31:16] == 16'h0000) else $error("upper bits set");
  slverr_data_a: assert property (s_axi_rvalid && s_axi_rresp == 2'h2
    |-> s_axi_rdata == 32'h0) else $error("error data");
  t1_pulse_a: assert property (timer1Irq_q |=> !timer1Irq_q)
    else $error("timer one pulse long");
  t2_pulse_a: assert property (timer2Irq_q |=> !timer2Irq_q)
    else $error("timer two pulse long");
  cover property (timer1Irq_q);
  cover property (timer2Irq_q ##1 !timer2Irq_q [*7] ##1 timer2Irq_q);
  cover property (irq_q && s_axi_rvalid);
endmodule // timer_trio_monitor

/* File: sim/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic        clk, rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic        timer1Irq_q, timer2Irq_q, irq_q;
  logic [5:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdVal, held;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [5:0]  rstAddr [11] = '{6'h00, 6'h04, 6'h08, 6'h0C, 6'h10,
                                6'h14, 6'h18, 6'h1C, 6'h20, 6'h24, 6'h28};
  logic [31:0] rstVal [11] = '{32'h0, 32'hFFFF, 32'h0, 32'hFFFF, 32'h0,
                               32'h4, 32'h4, 32'h0, 32'h0, 32'h4, 32'h0};
  int          err_total, samples_checked, gap, since2, lastGap;
  // short base tick keeps each countdown to a few dozen cycles
  timer_trio #(.BASE_CYCLES(4)) timer_trio_inst (.clk, .rst_b,
    .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
    .s_axi_araddr, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .s_axi_rresp, .timer1Irq_q, .timer2Irq_q, .irq_q);
  // ********
  // helpers
  // ********
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d,
                    input logic [1:0] r = 2'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
    chk({30'h0, s_axi_bresp}, {30'h0, r});
    @(posedge clk);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] e,
                    input logic [1:0] r = 2'h0, input bit cmp = 1'b1);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
    rdVal = s_axi_rdata;
    chk({30'h0, s_axi_rresp}, {30'h0, r});
    if (cmp) chk(rdVal, e);
    @(posedge clk);
  endtask
  task automatic waitPulse(input bit sel, input int lim, input bit want);
    gap = 0;
    do begin
      @(posedge clk);
      gap++;
    end while (!(sel ? timer2Irq_q : timer1Irq_q) && gap < lim);
    chk({31'h0, sel ? timer2Irq_q : timer1Irq_q}, {31'h0, want});
  endtask
  task automatic conclude();
    if (err_total == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // distance between timer two pulses, in clocks
  always @(posedge clk) begin
    if (!rst_b) begin
      since2  <= 0;
      lastGap <= 0;
    end else begin
      since2 <= timer2Irq_q ? 1 : since2 + 1;
      if (timer2Irq_q) lastGap <= since2;
    end
  end
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    repeat (6000) @(posedge clk);
    err_total++;
    conclude();
  end
  initial begin
    {rst_b, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = 14'h0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'hF;
    repeat (3) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    foreach (rstAddr[i]) rd(rstAddr[i], rstVal[i]);
    rd(6'h2C, 32'h0, 2'h2);
    wr(6'h2C, 32'h1, 2'h2);
    wr(6'h14, 32'hFFFF_FFFF);
    rd(6'h14, 32'h7);
    wr(6'h04, 32'h3);
    wr(6'h28, 32'h3);
    wr(6'h00, 32'h8000);
    waitPulse(1'b0, 60, 1'b1);
    repeat (2) @(posedge clk);
    chk({31'h0, irq_q}, 32'h1);
    rd(6'h00, 32'h0);
    rd(6'h10, 32'h1);
    rd(6'h10, 32'h0);
    chk({31'h0, irq_q}, 32'h0);
    waitPulse(1'b0, 60, 1'b0);
    chk(gap, 60);
    // byte strobes: init high byte only, then control without byte one
    s_axi_wstrb <= 4'h2;
    wr(6'hA4 - 6'hA0, 32'hAB00);
    s_axi_wstrb <= 4'h1;
    wr(6'h00, 32'h8000);
    s_axi_wstrb <= 4'hF;
    rd(6'h04, 32'hAB03);
    rd(6'h00, 32'h0);
    wr(6'h28, 32'h1);
    wr(6'h18, 32'h7);
    wr(6'h0C, 32'h2);
    wr(6'h08, 32'hC000);
    waitPulse(1'b1, 60, 1'b1);
    waitPulse(1'b1, 60, 1'b1);
    @(posedge clk);
    chk(lastGap, 8);
    wr(6'h0C, 32'h5);
    waitPulse(1'b1, 60, 1'b1);
    @(posedge clk);
    chk(lastGap, 8);
    waitPulse(1'b1, 60, 1'b1);
    @(posedge clk);
    chk(lastGap, 20);
    chk({31'h0, irq_q}, 32'h0);
    wr(6'h18, 32'h6);
    waitPulse(1'b1, 90, 1'b1);
    waitPulse(1'b1, 90, 1'b1);
    @(posedge clk);
    chk(lastGap, 40);
    wr(6'h08, 32'h0);
    rd(6'h10, 32'h2);
    waitPulse(1'b1, 60, 1'b0);
    chk(gap, 60);
    wr(6'h24, 32'h7);
    rd(6'h24, 32'h7);
    wr(6'h1C, 32'h1);
    repeat (40) @(posedge clk);
    wr(6'h1C, 32'h0);
    rd(6'h20, 32'h0, 2'h0, 1'b0);
    held = rdVal;
    chk({28'h0, held[15:12]}, 32'hF);
    wr(6'h20, 32'h1234);
    repeat (20) @(posedge clk);
    rd(6'h20, held);
    conclude();
  end
endmodule // tb_top
bind timer_trio timer_trio_monitor mon_inst (.clk, .rst_b, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .timer1Irq_q, .timer2Irq_q,
  .irq_q);
